// [hdl/epa_pick.sv]
// chooses the most urgent pending interrupt
// assumes priorities and pending lines stable within a cycle
`timescale 1ns/1ns
module epa_pick #(
	parameter int N = 8,
	parameter int W = 4
) (
	input  wire logic [N-1:0]       pend_i,
	input  wire logic [N*W-1:0]     prio_i,
	input  wire logic [W-1:0]       gmask_i,
	epa_sel_if.src                  sel
);
	logic [N:0]         c_any;
	logic [7:0]         c_idx   [N+1];
	logic [W-1:0]       c_full  [N+1];
	assign c_any[0]  = 1'b0;
	assign c_idx[0]  = 8'h00;
	assign c_full[0] = '0;
	// ***************************************************
	// linear scan, strict less keeps the lowest number
	// ***************************************************
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_scan
			logic [W-1:0] p;
			logic         take;
			assign p = prio_i[g*W +: W];
			// smaller value wins, ties keep lower index
			assign take = pend_i[g] && (!c_any[g] || p < c_full[g]);
			assign c_any[g+1]  = c_any[g] | pend_i[g];
			assign c_idx[g+1]  = take ? 8'(g) : c_idx[g];
			assign c_full[g+1] = take ? p : c_full[g];
		end
	endgenerate
	assign sel.any   = c_any[N];
	assign sel.idx   = c_idx[N];
	assign sel.full  = c_full[N];
	assign sel.group = c_full[N] & gmask_i;
endmodule

// [hdl/epa_pkg.sv]
// package for the exception priority arbiter
// assumes a single core clock domain
package epa_pkg;
	// ***************************************************
	// sizes and fixed encodings
	// ***************************************************
	localparam int EPA_NUM_IRQ    = 8;
	localparam int EPA_PRIO_W     = 4;
	localparam int EPA_SPLIT_W    = 3;
	localparam int EPA_ADDR_W     = 32;
	// handler stack depth and parameter limits
	localparam int EPA_STK_D      = 4;
	localparam int EPA_MAX_IRQ    = 64;
	localparam int EPA_MAX_PRIO_W = 8;
	// exception numbers of the fixed and system exceptions
	localparam int EPA_EXC_W      = 8;
	localparam logic [7:0] EPA_EXC_NONE   = 8'h00;
	localparam logic [7:0] EPA_EXC_NMI    = 8'h02;
	localparam logic [7:0] EPA_EXC_HARD   = 8'h03;
	localparam logic [7:0] EPA_EXC_IRQ0   = 8'h10;
	// fixed ranks: lower is more urgent, below every configurable one
	localparam logic [1:0] EPA_RANK_NMI   = 2'h1;
	localparam logic [1:0] EPA_RANK_HARD  = 2'h2;
	localparam logic [1:0] EPA_RANK_CFG   = 2'h3;
	localparam logic [1:0] EPA_RANK_IDLE  = 2'h3;
	// fault kinds
	localparam int EPA_FLT_W      = 2;
	localparam logic [1:0] EPA_FLT_HARD   = 2'h0;
	localparam logic [1:0] EPA_FLT_MEM    = 2'h1;
	localparam logic [1:0] EPA_FLT_BUS    = 2'h2;
	localparam logic [1:0] EPA_FLT_USAGE  = 2'h3;
	typedef enum logic [2:0] {
		EPA_RUN  = 3'b001,
		EPA_LOCK = 3'b010,
		EPA_HALT = 3'b100
	} epa_state_e;
endpackage

// [hdl/epa_sel_if.sv]
// carries the winner of the pending scan between modules
// assumes single clock, purely combinational carrier
`timescale 1ns/1ns
interface epa_sel_if #(
	parameter int N = 8,
	parameter int W = 4
);
	logic         any;
	logic [7:0]   idx;
	logic [W-1:0] group;
	logic [W-1:0] full;
	modport src (output any, output idx, output group, output full);
	modport dst (input any, input idx, input group, input full);
endinterface

// [hdl/epa_top.sv]
// exception priority, preemption and lockup logic
// assumes the core answers take_o with ack_i and signals returns
`timescale 1ns/1ns
import epa_pkg::*;
module epa_top #(
	parameter int N_IRQ  = epa_pkg::EPA_NUM_IRQ,
	parameter int PRIO_W = epa_pkg::EPA_PRIO_W
) (
	input  wire logic                          mclk_i,
	input  wire logic                          sys_rst_i,
	input  wire logic [N_IRQ-1:0]              irq_i,
	input  wire logic                          nmi_i,
	input  wire logic                          prio_we_i,
	input  wire logic [7:0]                    prio_idx_i,
	input  wire logic [PRIO_W-1:0]             prio_val_i,
	input  wire logic [epa_pkg::EPA_SPLIT_W-1:0] split_i,
	input  wire logic                          ack_i,
	input  wire logic                          ret_i,
	input  wire logic                          late_i,
	input  wire logic                          fault_i,
	input  wire logic [epa_pkg::EPA_FLT_W-1:0] fault_kind_i,
	input  wire logic [epa_pkg::EPA_ADDR_W-1:0] fault_addr_i,
	input  wire logic                          dbg_halt_i,
	output logic                               take_o,
	output logic [7:0]                         take_exc_o,
	output logic                               unstack_o,
	output logic                               lockup_o,
	output logic [7:0]                         active_exc_o,
	output logic [3:0]                         fault_status_o,
	output logic [epa_pkg::EPA_ADDR_W-1:0]     mem_manage_fault_address_o,
	output logic [epa_pkg::EPA_ADDR_W-1:0]     bus_fault_address_o
);
	import epa_pkg::*;
	if (N_IRQ < 1 || N_IRQ > EPA_MAX_IRQ || PRIO_W < 1 ||
		PRIO_W > EPA_MAX_PRIO_W) begin : g_bad_param
		$error("epa_top: unsupported N_IRQ or PRIO_W");
	end
	// ***************************************************
	// priority store and pending latches
	// ***************************************************
	logic [N_IRQ*PRIO_W-1:0] prio_reg;
	logic [N_IRQ-1:0]        pend_reg;
	logic                    nmi_pend_reg;
	logic                    hard_pend_reg;
	logic [7:0]              act_reg;
	logic [1:0]              act_rank_reg;
	logic [PRIO_W-1:0]       act_grp_reg;
	logic [7:0]              stk_exc_reg  [EPA_STK_D];
	logic [1:0]              stk_rank_reg [EPA_STK_D];
	logic [PRIO_W-1:0]       stk_grp_reg  [EPA_STK_D];
	logic [2:0]              depth_reg;
	epa_state_e              state_reg;
	logic                    lock_nmi_reg;
	logic [PRIO_W-1:0]       gmask;
	logic                    fault_hard;
	epa_sel_if #(.N(N_IRQ), .W(PRIO_W)) sel ();
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			prio_reg <= '0;
		else if (prio_we_i && prio_idx_i < 8'(N_IRQ))
			prio_reg[prio_idx_i*PRIO_W +: PRIO_W] <= prio_val_i;
	end
	// group mask keeps the upper bits above the split point
	always_comb begin
		gmask = '1;
		for (int b = 0; b < PRIO_W; b++)
			if (b < int'(split_i))
				gmask[b] = 1'b0;
	end
	epa_pick #(.N(N_IRQ), .W(PRIO_W)) u_pick (
		.pend_i  (pend_reg),
		.prio_i  (prio_reg),
		.gmask_i (gmask),
		.sel     (sel)
	);
	// ***************************************************
	// arbitration: fixed ranks beat configurable ones
	// ***************************************************
	logic       cand_cfg_ok;
	logic       in_lock;
	logic       stk_full;
	assign in_lock = state_reg != EPA_RUN;
	// only a hard fault pends the hard fault handler
	assign fault_hard = fault_i && fault_kind_i == EPA_FLT_HARD;
	// full stack refuses every take, so no pending bit is lost
	assign stk_full = depth_reg == 3'(EPA_STK_D);
	// interrupt preempts only on strictly better group
	assign cand_cfg_ok = sel.any &&
		(act_rank_reg == EPA_RANK_IDLE && act_reg == EPA_EXC_NONE ||
		 act_rank_reg == EPA_RANK_CFG && act_reg != EPA_EXC_NONE &&
		 sel.group < act_grp_reg);
	always_comb begin
		take_o     = 1'b0;
		take_exc_o = EPA_EXC_NONE;
		if (!in_lock && !ret_i && !stk_full) begin
			// fixed negative ranks always outrank configurable
			if (nmi_pend_reg && act_rank_reg > EPA_RANK_NMI) begin
				take_o     = 1'b1;
				take_exc_o = EPA_EXC_NMI;
			end else if (hard_pend_reg && act_rank_reg > EPA_RANK_HARD) begin
				take_o     = 1'b1;
				take_exc_o = EPA_EXC_HARD;
			end else if (cand_cfg_ok) begin
				take_o     = 1'b1;
				take_exc_o = EPA_EXC_IRQ0 + sel.idx;
			end
		end
	end
	// context a return resumes: the top of the handler stack
	logic [1:0]        stk_top;
	logic [1:0]        ret_rank;
	logic [PRIO_W-1:0] ret_grp;
	logic              ret_thread;
	logic              pend_ok;
	logic              ret_pop;
	assign stk_top    = 2'(depth_reg - 3'h1);
	assign ret_rank   = stk_rank_reg[stk_top];
	assign ret_grp    = stk_grp_reg[stk_top];
	assign ret_thread = stk_exc_reg[stk_top] == EPA_EXC_NONE;
	// pending work that would run in place of the resumed context
	assign pend_ok = nmi_pend_reg && ret_rank > EPA_RANK_NMI ||
		hard_pend_reg && ret_rank > EPA_RANK_HARD ||
		sel.any && (ret_thread ||
		ret_rank == EPA_RANK_CFG && sel.group < ret_grp);
	// finished handler leaves the stack unless locked up; pend_ok tail chains
	assign ret_pop = ret_i && !in_lock && act_reg != EPA_EXC_NONE &&
		depth_reg != 3'h0;
	// a return unstacks only if nothing pending may run now
	always_comb begin
		unstack_o = ret_pop && !late_i && !pend_ok;
	end
	// ***************************************************
	// pending state, set wins over clear
	// ***************************************************
	logic       took;
	assign took = take_o && ack_i;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			pend_reg <= '0;
		else
			for (int i = 0; i < N_IRQ; i++)
				if (irq_i[i])
					pend_reg[i] <= 1'b1;
				else if (took && take_exc_o == EPA_EXC_IRQ0 + 8'(i))
					pend_reg[i] <= 1'b0;
	end
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			nmi_pend_reg <= 1'b0;
		else if (nmi_i)
			nmi_pend_reg <= 1'b1;
		else if (took && take_exc_o == EPA_EXC_NMI)
			nmi_pend_reg <= 1'b0;
	end
	// ***************************************************
	// active handler stack
	// ***************************************************
	logic hf_in_fixed;
	assign hf_in_fixed = fault_i && fault_kind_i == EPA_FLT_HARD &&
		(act_reg == EPA_EXC_NMI || act_reg == EPA_EXC_HARD);
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i)
			hard_pend_reg <= 1'b0;
		else if (fault_hard && !hf_in_fixed)
			hard_pend_reg <= 1'b1;
		else if (took && take_exc_o == EPA_EXC_HARD)
			hard_pend_reg <= 1'b0;
	end
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			act_reg      <= EPA_EXC_NONE;
			act_rank_reg <= EPA_RANK_IDLE;
			act_grp_reg  <= '1;
			depth_reg    <= 3'h0;
			for (int k = 0; k < EPA_STK_D; k++) begin
				stk_exc_reg[k]  <= EPA_EXC_NONE;
				stk_rank_reg[k] <= EPA_RANK_IDLE;
				stk_grp_reg[k]  <= '1;
			end
		end else if (took && !stk_full) begin
			stk_exc_reg[depth_reg[1:0]]  <= act_reg;
			stk_rank_reg[depth_reg[1:0]] <= act_rank_reg;
			stk_grp_reg[depth_reg[1:0]]  <= act_grp_reg;
			depth_reg <= depth_reg + 3'h1;
			act_reg   <= take_exc_o;
			if (take_exc_o == EPA_EXC_NMI) begin
				act_rank_reg <= EPA_RANK_NMI;
				act_grp_reg  <= '0;
			end else if (take_exc_o == EPA_EXC_HARD) begin
				act_rank_reg <= EPA_RANK_HARD;
				act_grp_reg  <= '0;
			end else begin
				act_rank_reg <= EPA_RANK_CFG;
				act_grp_reg  <= sel.group;
			end
		end else if (ret_pop) begin
			act_reg      <= stk_exc_reg[stk_top];
			act_rank_reg <= ret_rank;
			act_grp_reg  <= ret_grp;
			depth_reg    <= depth_reg - 3'h1;
		end
	end
	assign active_exc_o = act_reg;
	// ***************************************************
	// lockup
	// ***************************************************
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state_reg    <= EPA_RUN;
			lock_nmi_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				EPA_RUN: if (hf_in_fixed) begin
					state_reg    <= EPA_LOCK;
					lock_nmi_reg <= act_reg == EPA_EXC_NMI;
				end
				EPA_LOCK: if (dbg_halt_i)
					state_reg <= EPA_HALT;
				else if (nmi_i && !lock_nmi_reg)
					state_reg <= EPA_RUN;
				EPA_HALT: if (!dbg_halt_i)
					state_reg <= EPA_RUN;
				default: state_reg <= EPA_RUN;
			endcase
		end
	end
	assign lockup_o = state_reg == EPA_LOCK;
	// ***************************************************
	// fault status and address capture
	// ***************************************************
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			fault_status_o             <= 4'h0;
			mem_manage_fault_address_o <= '0;
			bus_fault_address_o        <= '0;
		end else if (fault_i) begin
			fault_status_o[fault_kind_i] <= 1'b1;
			if (fault_kind_i == EPA_FLT_MEM)
				mem_manage_fault_address_o <= fault_addr_i;
			if (fault_kind_i == EPA_FLT_BUS)
				bus_fault_address_o <= fault_addr_i;
		end
	end
endmodule

// [verif/epa_core_model.sv]
// core stand-in that accepts takes from the arbiter
// assumes hold_i from the bench stalls acceptance
`timescale 1ns/1ns
module epa_core_model (
	input  wire logic mclk_i,
	input  wire logic take_o,
	input  wire logic lockup_o,
	input  wire logic hold_i,
	output logic      ack_i
);
	initial ack_i = 1'b0;
	// one accept per take, none while locked up
	always @(posedge mclk_i) begin
		ack_i <= take_o && !ack_i && !hold_i && !lockup_o;
	end
endmodule

// [verif/epa_monitor.sv]
// port assertions for the exception priority arbiter
// assumes bind onto epa_top, one clock, sync reset
`timescale 1ns/1ns
module epa_monitor (
	input wire logic                          mclk_i,
	input wire logic                          sys_rst_i,
	input wire logic                          nmi_i,
	input wire logic                          ack_i,
	input wire logic                          ret_i,
	input wire logic                          late_i,
	input wire logic                          fault_i,
	input wire logic [epa_pkg::EPA_FLT_W-1:0] fault_kind_i,
	input wire logic                          dbg_halt_i,
	input wire logic                          take_o,
	input wire logic [7:0]                    take_exc_o,
	input wire logic                          unstack_o,
	input wire logic                          lockup_o,
	input wire logic [7:0]                    active_exc_o,
	input wire logic [3:0]                    fault_status_o,
	input wire logic [31:0]                   mem_manage_fault_address_o,
	input wire logic [31:0]                   bus_fault_address_o
);
	import epa_pkg::*;
	// ***************************************************
	// assertions
	// ***************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	wire logic hf = fault_i && fault_kind_i == EPA_FLT_HARD;
	wire logic in_fix = active_exc_o == EPA_EXC_NMI
		|| active_exc_o == EPA_EXC_HARD;
	lock_no_take_a: assert property (lockup_o |-> !take_o)
		else $error("take while locked");
	ret_no_take_a: assert property (ret_i |-> !take_o)
		else $error("take during return");
	late_no_pop_a: assert property (ret_i && late_i |-> !unstack_o)
		else $error("unstack on late return");
	pop_on_ret_a: assert property (unstack_o |-> ret_i)
		else $error("unstack without return");
	take_load_a: assert property (take_o && ack_i && !fault_i
		|=> active_exc_o == $past(take_exc_o))
		else $error("active not loaded");
	lock_enter_a: assert property (hf && in_fix && !ack_i
		&& !dbg_halt_i |=> lockup_o)
		else $error("no lockup");
	lock_hold_a: assert property (lockup_o && !nmi_i
		&& !dbg_halt_i |=> lockup_o)
		else $error("lockup left");
	flt_flag_a: assert property (fault_i
		|=> fault_status_o[$past(fault_kind_i)])
		else $error("fault flag missing");
	mem_addr_a: assert property (!(fault_i
		&& fault_kind_i == EPA_FLT_MEM)
		|=> $stable(mem_manage_fault_address_o))
		else $error("mem address moved");
	bus_addr_a: assert property (!(fault_i
		&& fault_kind_i == EPA_FLT_BUS)
		|=> $stable(bus_fault_address_o))
		else $error("bus address moved");
	cover property (take_o && ack_i);
	cover property (lockup_o);
	cover property (unstack_o);
endmodule
bind epa_top epa_monitor i_mon (.mclk_i, .sys_rst_i, .nmi_i, .ack_i,
	.ret_i, .late_i, .fault_i, .fault_kind_i, .dbg_halt_i, .take_o,
	.take_exc_o, .unstack_o, .lockup_o, .active_exc_o, .fault_status_o,
	.mem_manage_fault_address_o, .bus_fault_address_o);

// [verif/epa_top_test.sv]
// self-checking bench for the exception priority arbiter
// assumes epa_monitor bound and epa_core_model answering takes
`timescale 1ns/1ns
module epa_top_test;
	import epa_pkg::*;
	logic        mclk_i       = 1'b0;
	logic        sys_rst_i    = 1'b1;
	logic [7:0]  irq_i        = 8'h00;
	logic        nmi_i        = 1'b0;
	logic        prio_we_i    = 1'b0;
	logic [7:0]  prio_idx_i   = 8'h00;
	logic [3:0]  prio_val_i   = 4'h0;
	logic [2:0]  split_i      = 3'h0;
	logic        ret_i        = 1'b0;
	logic        late_i       = 1'b0;
	logic        fault_i      = 1'b0;
	logic [1:0]  fault_kind_i = 2'h0;
	logic [31:0] fault_addr_i = 32'h0;
	logic        dbg_halt_i   = 1'b0;
	logic        hold         = 1'b1;
	logic        ack_i, take_o, unstack_o, lockup_o;
	logic [7:0]  take_exc_o, active_exc_o;
	logic [3:0]  fault_status_o;
	logic [31:0] mem_a, bus_a;
	int          error_cnt    = 0;
	int          tests_run    = 0;
	always #25 mclk_i = ~mclk_i;
	epa_top i_dut (.mclk_i, .sys_rst_i, .irq_i, .nmi_i, .prio_we_i,
		.prio_idx_i, .prio_val_i, .split_i, .ack_i, .ret_i, .late_i,
		.fault_i, .fault_kind_i, .fault_addr_i, .dbg_halt_i, .take_o,
		.take_exc_o, .unstack_o, .lockup_o, .active_exc_o,
		.fault_status_o, .mem_manage_fault_address_o(mem_a),
		.bus_fault_address_o(bus_a));
	epa_core_model i_core (.mclk_i, .take_o, .lockup_o, .hold_i(hold),
		.ack_i);
	// ***************************************************
	// helpers
	// ***************************************************
	task tick; @(posedge mclk_i); endtask
	task chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task rst;
		tick;
		sys_rst_i <= 1'b1;
		hold <= 1'b1;
		repeat (8) tick;
		sys_rst_i <= 1'b0;
	endtask
	task pulse(input logic [7:0] m, input logic n);
		tick; irq_i <= m; nmi_i <= n;
		tick; irq_i <= 8'h00; nmi_i <= 1'b0;
	endtask
	task wp(input logic [7:0] i, input logic [3:0] v);
		tick; prio_idx_i <= i; prio_val_i <= v; prio_we_i <= 1'b1;
		tick; prio_we_i <= 1'b0;
	endtask
	task flt(input logic [1:0] k, input logic [31:0] a);
		tick; fault_i <= 1'b1; fault_kind_i <= k; fault_addr_i <= a;
		tick; fault_i <= 1'b0;
	endtask
	task rt(input logic l, input logic e);
		tick; ret_i <= 1'b1; late_i <= l;
		#1 chk("unstack", e, unstack_o);
		tick; ret_i <= 1'b0; late_i <= 1'b0;
	endtask
	// release the core until the expected handler runs
	task go(input logic [7:0] e);
		hold <= 1'b0;
		for (int i = 0; i < 10 && active_exc_o !== e; i++) tick;
		hold <= 1'b1;
		#1 chk("active", e, active_exc_o);
	endtask
	// ***************************************************
	// scenarios
	// ***************************************************
	task t_tie;
		rst;
		#1 chk("status", 4'h0, fault_status_o);
		pulse(8'h03, 1'b0);
		#1 chk("take", 8'h10, take_exc_o);
		go(8'h10);
		pulse(8'h02, 1'b0);
		#1 chk("take_o", 1'b0, take_o);
		rt(1'b0, 1'b0);
		go(8'h11);
		rt(1'b0, 1'b1);
		pulse(8'h04, 1'b0);
		go(8'h12);
		rt(1'b1, 1'b0);
		$display("test tie done");
	endtask
	task t_prio;
		rst;
		wp(8'h00, 4'h8);
		wp(8'h01, 4'h4);
		pulse(8'h03, 1'b0);
		#1 chk("take", 8'h11, take_exc_o);
		go(8'h11);
		pulse(8'h04, 1'b0);
		#1 chk("take", 8'h12, take_exc_o);
		pulse(8'h00, 1'b1);
		#1 chk("take", 8'h02, take_exc_o);
		go(8'h02);
		$display("test prio done");
	endtask
	task t_group;
		rst;
		tick; split_i <= 3'h2;
		wp(8'h00, 4'h6);
		wp(8'h01, 4'h5);
		wp(8'h02, 4'h4);
		wp(8'h03, 4'h1);
		pulse(8'h03, 1'b0);
		#1 chk("take", 8'h11, take_exc_o);
		go(8'h11);
		pulse(8'h04, 1'b0);
		#1 chk("take_o", 1'b0, take_o);
		pulse(8'h08, 1'b0);
		#1 chk("take", 8'h13, take_exc_o);
		go(8'h13);
		$display("test group done");
	endtask
	task t_lock;
		rst;
		pulse(8'h00, 1'b1);
		go(8'h02);
		flt(EPA_FLT_HARD, 32'h0);
		#1 chk("lockup", 1'b1, lockup_o);
		pulse(8'h00, 1'b1);
		#1 chk("lockup", 1'b1, lockup_o);
		tick; dbg_halt_i <= 1'b1;
		tick; dbg_halt_i <= 1'b0;
		#1 chk("lockup", 1'b0, lockup_o);
		rst;
		flt(EPA_FLT_HARD, 32'h0);
		go(8'h03);
		flt(EPA_FLT_HARD, 32'h0);
		#1 chk("lockup", 1'b1, lockup_o);
		pulse(8'h00, 1'b1);
		#1 chk("lockup", 1'b0, lockup_o);
		$display("test lock done");
	endtask
	task t_fault;
		rst;
		flt(EPA_FLT_MEM, 32'h1000_0040);
		flt(EPA_FLT_BUS, 32'h2000_0080);
		flt(EPA_FLT_USAGE, 32'h3000_00c0);
		#1 chk("status", 4'he, fault_status_o);
		chk("mem_addr", 32'h1000_0040, mem_a);
		chk("bus_addr", 32'h2000_0080, bus_a);
		$display("test fault done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) tick;
		error_cnt++;
		stop_test;
	end
	initial begin
		t_tie;
		t_prio;
		t_group;
		t_lock;
		t_fault;
		stop_test;
	end
endmodule
